// [rtl/pmc_pkg.sv]
package pmc_pkg;

    // Register port geometry.
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;

    // Register offsets on the plain register port.
    localparam logic [1:0] ADDR_OSC_CTRL = 2'h0;
    localparam logic [1:0] ADDR_TMR_CTRL = 2'h1;
    localparam logic [1:0] ADDR_MODE = 2'h2;

    // Field positions.
    localparam int OSC_IDLE_BIT = 7;
    localparam int OSC_PRI_FLAG_BIT = 3;
    localparam int TMR_SEC_FLAG_BIT = 6;
    localparam int TMR_SEC_EN_BIT = 3;

    // Clock-source select encodings and reset values.
    localparam logic [1:0] SEL_DEFAULT = 2'h0;
    localparam logic [1:0] SEL_SEC = 2'h1;
    localparam logic [1:0] SEL_PRI = 2'h2;
    localparam logic [1:0] SEL_INT = 2'h3;
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic IDLE_RESET = 1'b0;
    localparam logic SEC_EN_RESET = 1'b0;

    // Glitch-free switch pause, in source cycles.
    localparam int OLD_SRC_CYCLES = 2;
    localparam int NEW_SRC_CYCLES = 4;
    localparam int PAUSE_CYCLES = OLD_SRC_CYCLES + NEW_SRC_CYCLES;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] PAUSE_LOAD = CNT_W'(PAUSE_CYCLES - 1);

    // Pin synchroniser depth.
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_PRI = 2'b01,
        SRC_SEC = 2'b10,
        SRC_INT = 2'b11
    } pmc_src_t;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b000,
        ST_RUN = 3'b001,
        ST_WAIT = 3'b010,
        ST_SWITCH = 3'b011,
        ST_IDLE = 3'b100,
        ST_SLEEP = 3'b101,
        ST_WAKE = 3'b110
    } pmc_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } pmc_bus_t;

    typedef struct packed {
        logic cpu_en;
        logic periph_en;
        pmc_src_t src;
    } pmc_clk_t;

    typedef struct packed {
        logic pri_en;
        logic sec_en;
        logic int_en;
    } pmc_osc_t;

    typedef struct packed {
        logic default_src;
        logic two_speed;
        logic fail_safe;
        logic watchdog;
    } pmc_cfg_t;

endpackage : pmc_pkg

// [rtl/pmc_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module pmc_pin_sync #(
    parameter int W = 2
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    import pmc_pkg::*;

    logic [SYNC_STAGES-1:0][W-1:0] stage;
    logic [SYNC_STAGES-1:0][W-1:0] next_stage;
    logic [W-1:0] next_dout;

    ////////////////////////////////////////////////////////////////////////////
    // Shift the pins along; a bit changes only once the last two stages agree.
    always_comb
    begin
        next_stage = {stage[SYNC_STAGES-2:0], din};
        next_dout = dout;
        for (int i = 0; i < W; i++)
        begin
            if (stage[1][i] == stage[2][i])
            begin
                next_dout[i] = stage[2][i];
            end
        end
    end

    // Registers only; the first stage feeds nothing but the second.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stage <= '0;
            dout <= '0;
        end
        else if (ce)
        begin
            stage <= next_stage;
            dout <= next_dout;
        end
    end

endmodule : pmc_pin_sync

`default_nettype wire

// [rtl/pmc_switcher.sv]
`timescale 1ns/1ps
`default_nettype none

module pmc_switcher (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire pmc_pkg::pmc_bus_t bus,
    output logic [pmc_pkg::DATA_W-1:0] rdata,
    input wire logic halt_exec,
    input wire logic wake_event,
    input wire pmc_pkg::pmc_cfg_t cfg,
    input wire logic pri_osc_ready_pin,
    input wire logic sec_osc_running_pin,
    output pmc_pkg::pmc_clk_t clk_out,
    output pmc_pkg::pmc_osc_t osc_en,
    output logic primary_ready_flag,
    output logic secondary_active_flag
);
    import pmc_pkg::*;

    logic idle_on_halt;
    logic [1:0] clock_source_select;
    logic secondary_osc_enable;
    logic next_idle_on_halt;
    logic [1:0] next_clock_source_select;
    logic next_secondary_osc_enable;
    logic [DATA_W-1:0] next_rdata;
    pmc_state_t state;
    pmc_state_t next_state;
    pmc_src_t cur_src;
    pmc_src_t next_cur_src;
    pmc_src_t tgt_src;
    pmc_src_t next_tgt_src;
    pmc_src_t want_src;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    pmc_clk_t next_clk_out;
    pmc_osc_t next_osc_en;
    logic next_primary_ready_flag;
    logic next_secondary_active_flag;
    logic [1:0] osc_sync;
    logic pri_ready;
    logic sec_running;
    logic sec_refused;
    logic pending;
    logic [1:0] osc_armed;
    logic [1:0] next_osc_armed;

    ////////////////////////////////////////////////////////////////////////////
    // Maps a select value onto the oscillator it names.
    function automatic pmc_src_t decode_src(input logic [1:0] sel, input logic dflt);
        pmc_src_t s;
        case (sel)
            SEL_SEC: s = SRC_SEC;
            SEL_PRI: s = SRC_PRI;
            SEL_INT: s = SRC_INT;
            default: s = dflt ? SRC_PRI : SRC_INT;
        endcase
        return s;
    endfunction : decode_src

    // Tells whether an oscillator is stable enough to take over.
    function automatic logic src_ready(input pmc_src_t s, input logic pr, input logic sr);
        logic r;
        case (s)
            SRC_PRI: r = pr;
            SRC_SEC: r = sr;
            SRC_INT: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : src_ready

    ////////////////////////////////////////////////////////////////////////////
    // The oscillator status pins come from other clocks, so they are synchronised.
    pmc_pin_sync #(
        .W(2)
    ) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .din({pri_osc_ready_pin, sec_osc_running_pin}),
        .dout(osc_sync)
    );

    // Decoded wishes of software.
    assign pri_ready = osc_sync[1] && osc_armed[1];
    assign sec_running = osc_sync[0] && osc_armed[0];
    assign want_src = decode_src(clock_source_select, cfg.default_src);
    assign sec_refused = (want_src == SRC_SEC) && !secondary_osc_enable;
    assign pending = (want_src != cur_src) && !sec_refused;

    ////////////////////////////////////////////////////////////////////////////
    // Register port: writes update software bits, reads answer one cycle later.
    always_comb
    begin
        next_idle_on_halt = idle_on_halt;
        next_clock_source_select = clock_source_select;
        next_secondary_osc_enable = secondary_osc_enable;
        next_rdata = '0;
        if (bus.wr)
        begin
            case (bus.addr)
                ADDR_OSC_CTRL:
                begin
                    next_idle_on_halt = bus.wdata[OSC_IDLE_BIT];
                    next_clock_source_select = bus.wdata[1:0];
                end
                ADDR_TMR_CTRL: next_secondary_osc_enable = bus.wdata[TMR_SEC_EN_BIT];
                default: next_rdata = '0;
            endcase
        end
        if (bus.rd)
        begin
            case (bus.addr)
                ADDR_OSC_CTRL:
                begin
                    next_rdata[OSC_IDLE_BIT] = idle_on_halt;
                    next_rdata[OSC_PRI_FLAG_BIT] = primary_ready_flag;
                    next_rdata[1:0] = clock_source_select;
                end
                ADDR_TMR_CTRL:
                begin
                    next_rdata[TMR_SEC_FLAG_BIT] = secondary_active_flag;
                    next_rdata[TMR_SEC_EN_BIT] = secondary_osc_enable;
                end
                ADDR_MODE: next_rdata = {1'b0, cur_src, 2'h0, state};
                default: next_rdata = '0;
            endcase
        end
    end

    // Hardware never rewrites the select or idle bits, even on wake.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            idle_on_halt <= IDLE_RESET;
            clock_source_select <= SEL_RESET;
            secondary_osc_enable <= SEC_EN_RESET;
            rdata <= '0;
        end
        else if (ce)
        begin
            idle_on_halt <= next_idle_on_halt;
            clock_source_select <= next_clock_source_select;
            secondary_osc_enable <= next_secondary_osc_enable;
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode sequencer: run, switch, idle, sleep and wake.
    always_comb
    begin
        next_state = state;
        next_cur_src = cur_src;
        next_tgt_src = tgt_src;
        next_cnt = cnt;
        case (state)
            ST_BOOT:
            begin
                // The source is chosen one edge after reset, from the straps.
                next_cur_src = cfg.two_speed ? SRC_INT : want_src;
                next_state = ST_RUN;
            end
            ST_RUN:
            begin
                if (halt_exec)
                begin
                    if (!idle_on_halt)
                    begin
                        next_state = ST_SLEEP;
                        next_cur_src = SRC_NONE;
                    end
                    else if (want_src == cur_src)
                    begin
                        next_state = ST_IDLE;
                    end
                end
                else if (pending)
                begin
                    // A new select becomes the target at once; the source changes only after the pause, preceded by the wait when it is not yet ready.
                    next_tgt_src = want_src;
                    if (src_ready(want_src, pri_ready, sec_running))
                    begin
                        next_state = ST_SWITCH;
                        next_cnt = PAUSE_LOAD;
                    end
                    else
                    begin
                        next_state = ST_WAIT;
                    end
                end
            end
            ST_WAIT:
            begin
                // Software changed its mind; decide again from run.
                if (want_src != tgt_src)
                begin
                    next_state = ST_RUN;
                end
                else if (src_ready(tgt_src, pri_ready, sec_running))
                begin
                    next_state = ST_SWITCH;
                    next_cnt = PAUSE_LOAD;
                end
            end
            ST_SWITCH:
            begin
                // Clock paused for old plus new source cycles.
                if (cnt == '0)
                begin
                    next_cur_src = tgt_src;
                    next_state = ST_RUN;
                end
                else
                begin
                    next_cnt = cnt - CNT_W'(1);
                end
            end
            ST_IDLE:
            begin
                if (wake_event)
                begin
                    next_state = ST_RUN;
                end
            end
            ST_SLEEP:
            begin
                if (wake_event)
                begin
                    if (cfg.two_speed || cfg.fail_safe)
                    begin
                        next_cur_src = SRC_INT;
                        next_state = ST_RUN;
                    end
                    else
                    begin
                        next_tgt_src = want_src;
                        next_state = ST_WAKE;
                    end
                end
            end
            ST_WAKE:
            begin
                // Unclocked until the selected source is ready.
                if (src_ready(tgt_src, pri_ready, sec_running))
                begin
                    next_cur_src = tgt_src;
                    next_state = ST_RUN;
                end
            end
            default:
            begin
                next_state = ST_BOOT;
            end
        endcase
    end

    // Clock gates, primary and internal oscillator enables and flags follow the next state; the Timer1 enable follows its next register bit.
    always_comb
    begin
        next_clk_out.cpu_en = (next_state == ST_RUN)
            || (next_state == ST_WAIT && next_tgt_src != SRC_SEC);
        next_clk_out.periph_en = next_clk_out.cpu_en || (next_state == ST_IDLE);
        next_clk_out.src = next_clk_out.periph_en ? next_cur_src : SRC_NONE;
        next_osc_en.pri_en = (next_cur_src == SRC_PRI)
            || ((next_state == ST_WAIT || next_state == ST_SWITCH || next_state == ST_WAKE)
            && next_tgt_src == SRC_PRI);
        next_osc_en.sec_en = next_secondary_osc_enable;
        next_osc_en.int_en = (next_cur_src == SRC_INT) || (next_state == ST_BOOT)
            || ((next_state == ST_WAIT || next_state == ST_SWITCH) && next_tgt_src == SRC_INT)
            || cfg.watchdog || cfg.fail_safe;
        next_primary_ready_flag = (next_cur_src == SRC_PRI);
        next_secondary_active_flag = (next_cur_src == SRC_SEC);
        // A ready level counts only once seen low since the enable rose, so a stale synchroniser level is ignored.
        next_osc_armed = {osc_en.pri_en, osc_en.sec_en} & (osc_armed | ~osc_sync);
    end

    // Sequencer and output registers.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= ST_BOOT;
            cur_src <= SRC_NONE;
            tgt_src <= SRC_NONE;
            cnt <= '0;
            clk_out <= '0;
            osc_en <= '0;
            primary_ready_flag <= 1'b0;
            secondary_active_flag <= 1'b0;
            osc_armed <= '0;
        end
        else if (ce)
        begin
            state <= next_state;
            cur_src <= next_cur_src;
            tgt_src <= next_tgt_src;
            cnt <= next_cnt;
            clk_out <= next_clk_out;
            osc_en <= next_osc_en;
            primary_ready_flag <= next_primary_ready_flag;
            secondary_active_flag <= next_secondary_active_flag;
            osc_armed <= next_osc_armed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the sequencer.
    sequence s_switch_start;
        $rose(state == ST_SWITCH);
    endsequence

    sequence s_switch_body;
        (state == ST_SWITCH && !clk_out.cpu_en)[*6] ##1 (state == ST_RUN);
    endsequence

    a_reset_select: assert property (@(posedge mclk iff ce) disable iff (sys_rst)
        (state == ST_BOOT) |-> (clock_source_select == SEL_RESET))
        else $error("Select field not cleared by reset.");

    a_boot_primary: assert property (@(posedge mclk iff ce) disable iff (sys_rst)
        (state == ST_BOOT && !cfg.two_speed && want_src == SRC_PRI)
        |=> (primary_ready_flag && clk_out.cpu_en && clk_out.src == SRC_PRI))
        else $error("Reset did not start in primary run.");

    a_idle_entry: assert property (@(posedge mclk iff ce) disable iff (sys_rst)
        (state == ST_RUN && halt_exec && idle_on_halt && want_src == cur_src)
        |=> (!clk_out.cpu_en && clk_out.periph_en && clk_out.src == $past(cur_src)))
        else $error("Idle entry clocks wrong.");

    a_sleep_entry: assert property (@(posedge mclk iff ce) disable iff (sys_rst)
        (state == ST_RUN && halt_exec && !idle_on_halt)
        |=> (!primary_ready_flag && !secondary_active_flag && !clk_out.periph_en))
        else $error("Sleep entry left a flag or clock on.");

    a_switch_pause: assert property (@(posedge mclk iff ce) disable iff (sys_rst)
        s_switch_start |-> s_switch_body)
        else $error("Switch pause has wrong length.");

    a_sec_refused: assert property (@(posedge mclk iff ce) disable iff (sys_rst)
        (state == ST_RUN && sec_refused && !halt_exec)
        |=> (state == ST_RUN && cur_src == $past(cur_src)))
        else $error("Timer1 selected while disabled.");

    a_flag_source: assert property (@(posedge mclk iff ce) disable iff (sys_rst)
        clk_out.cpu_en |-> (primary_ready_flag == (clk_out.src == SRC_PRI))
        && (secondary_active_flag == (clk_out.src == SRC_SEC)))
        else $error("Flags disagree with clock source.");

    a_wait_old_clock: assert property (@(posedge mclk iff ce) disable iff (sys_rst)
        (state == ST_WAIT && tgt_src == SRC_PRI) |-> (clk_out.cpu_en && clk_out.src == cur_src))
        else $error("Old clock stopped while primary starts.");

    a_wake_internal: assert property (@(posedge mclk iff ce) disable iff (sys_rst)
        (state == ST_SLEEP && wake_event && (cfg.two_speed || cfg.fail_safe))
        |=> (clk_out.cpu_en && clk_out.src == SRC_INT && osc_en.int_en))
        else $error("Wake did not run from internal oscillator.");

endmodule : pmc_switcher

`default_nettype wire

// [bench/pmc_osc_model.sv]
`timescale 1ns/1ps
`default_nettype none

module pmc_osc_model #(
    parameter int PRI_DLY = 20,
    parameter int SEC_DLY = 30
) (
    input wire logic mclk,
    input wire logic pri_en,
    input wire logic sec_en,
    output logic pri_ready,
    output logic sec_running
);

    int pri_cnt = 0;
    int sec_cnt = 0;

    ////////////////////////////////////////////////////////////////
    // Each oscillator needs a start-up time and stops at once when disabled.
    always @(posedge mclk)
    begin
        pri_cnt <= !pri_en ? 0 : (pri_cnt < PRI_DLY) ? pri_cnt + 1 : pri_cnt;
        sec_cnt <= !sec_en ? 0 : (sec_cnt < SEC_DLY) ? sec_cnt + 1 : sec_cnt;
    end

    // Status levels rise only after the full start-up time.
    assign pri_ready = (pri_cnt >= PRI_DLY);
    assign sec_running = (sec_cnt >= SEC_DLY);

endmodule : pmc_osc_model

`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import pmc_pkg::*;

    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    pmc_bus_t bus = '0;
    logic [DATA_W-1:0] rdata;
    logic halt_exec = 1'b0;
    logic wake_event = 1'b0;
    pmc_cfg_t cfg = '{default_src: 1'b1, two_speed: 1'b0, fail_safe: 1'b0, watchdog: 1'b0};
    logic pri_rdy;
    logic secondary_run_mode;
    pmc_clk_t clk_out;
    pmc_osc_t osc_en;
    logic primary_ready_flag;
    logic secondary_active_flag;
    int err_total = 0;
    int n_compared = 0;
    int n;

    ////////////////////////////////////////////////////////////////
    // Clock of 40 ns period.
    always #20 mclk = ~mclk;

    pmc_switcher i_pmc_switcher (
        .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .bus(bus), .rdata(rdata),
        .halt_exec(halt_exec), .wake_event(wake_event), .cfg(cfg),
        .pri_osc_ready_pin(pri_rdy), .sec_osc_running_pin(secondary_run_mode),
        .clk_out(clk_out), .osc_en(osc_en), .primary_ready_flag(primary_ready_flag),
        .secondary_active_flag(secondary_active_flag)
    );

    pmc_osc_model i_pmc_osc_model (
        .mclk(mclk), .pri_en(osc_en.pri_en), .sec_en(osc_en.sec_en),
        .pri_ready(pri_rdy), .sec_running(secondary_run_mode)
    );

    ////////////////////////////////////////////////////////////////
    // Verdict, comparison and bus tasks.
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask : cyc

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask : wr

    // The read data stand only in the cycle after the strobe.
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        @(negedge mclk);
        chk("rdata", rdata, exp);
    endtask : rd

    // One-cycle halt or wake pulse, then let the mode settle.
    task automatic pulse(input bit w);
        @(posedge mclk);
        if (w)
            wake_event <= 1'b1;
        else
            halt_exec <= 1'b1;
        @(posedge mclk);
        wake_event <= 1'b0;
        halt_exec <= 1'b0;
        cyc(3);
    endtask : pulse

    // Bounded wait for the CPU to run from a given source; a timeout counts as a mismatch and ends the run.
    task automatic wait_src(input pmc_src_t s, input int lim);
        int i;
        i = 0;
        @(negedge mclk);
        while (!(clk_out.src === s && clk_out.cpu_en === 1'b1) && i < lim)
        begin
            @(negedge mclk);
            i++;
        end
        chk("src wait", 8'({clk_out.cpu_en, clk_out.src}), 8'({1'b1, s}));
        if (clk_out.src !== s || clk_out.cpu_en !== 1'b1)
        begin
            print_verdict();
        end
    endtask : wait_src

    task automatic do_reset(input pmc_cfg_t c);
        @(posedge mclk);
        sys_rst <= 1'b1;
        cfg <= c;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        cyc(3);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        cyc(3);
        chk("src", 8'(clk_out.src), 8'(SRC_PRI));
        chk("pri flag", 8'(primary_ready_flag), 8'h01);
        rd(ADDR_OSC_CTRL, 8'h08);
        rd(2'h3, 8'h00);
        // Switch primary to internal and measure the pause.
        wr(ADDR_OSC_CTRL, 8'h03);
        n = 0;
        while (clk_out.periph_en !== 1'b0 && n < 10)
        begin
            cyc(1);
            n++;
        end
        n = 0;
        while (clk_out.periph_en === 1'b0 && n < 20)
        begin
            cyc(1);
            n++;
        end
        chk("pause", 8'(n), 8'(PAUSE_CYCLES));
        chk("src", 8'(clk_out.src), 8'(SRC_INT));
        chk("pri flag", 8'(primary_ready_flag), 8'h00);
        chk("pri en", 8'(osc_en.pri_en), 8'h00);
        rd(ADDR_MODE, 8'h61);
        // Timer1 refused while its enable is clear.
        wr(ADDR_OSC_CTRL, 8'h01);
        cyc(10);
        chk("src", 8'(clk_out.src), 8'(SRC_INT));
        // Enable Timer1 and select it before it oscillates.
        wr(ADDR_TMR_CTRL, 8'h08);
        wr(ADDR_OSC_CTRL, 8'h01);
        cyc(4);
        chk("periph", 8'(clk_out.periph_en), 8'h00);
        wait_src(SRC_SEC, 200);
        chk("sec flag", 8'(secondary_active_flag), 8'h01);
        chk("pri flag", 8'(primary_ready_flag), 8'h00);
        // Back to primary: Timer1 clocks while primary starts.
        wr(ADDR_OSC_CTRL, 8'h02);
        cyc(4);
        chk("src", 8'(clk_out.src), 8'(SRC_SEC));
        chk("cpu", 8'(clk_out.cpu_en), 8'h01);
        wait_src(SRC_PRI, 200);
        chk("sec flag", 8'(secondary_active_flag), 8'h00);
        chk("sec en", 8'(osc_en.sec_en), 8'h01);
        rd(ADDR_OSC_CTRL, 8'h0A);
        rd(ADDR_TMR_CTRL, 8'h08);
        // Idle on the primary.
        wr(ADDR_OSC_CTRL, 8'h82);
        pulse(1'b0);
        chk("cpu", 8'(clk_out.cpu_en), 8'h00);
        chk("periph", 8'(clk_out.periph_en), 8'h01);
        chk("src", 8'(clk_out.src), 8'(SRC_PRI));
        pulse(1'b1);
        chk("cpu", 8'(clk_out.cpu_en), 8'h01);
        // Idle bit cleared: the next halt gives Sleep.
        wr(ADDR_OSC_CTRL, 8'h02);
        pulse(1'b0);
        chk("periph", 8'(clk_out.periph_en), 8'h00);
        chk("flags", 8'({primary_ready_flag, secondary_active_flag}), 8'h00);
        chk("pri en", 8'(osc_en.pri_en), 8'h00);
        chk("sec en", 8'(osc_en.sec_en), 8'h01);
        pulse(1'b1);
        chk("periph", 8'(clk_out.periph_en), 8'h00);
        wait_src(SRC_PRI, 200);
        chk("pri flag", 8'(primary_ready_flag), 8'h01);
        rd(ADDR_OSC_CTRL, 8'h0A);
        // Select 00 means internal, with watchdog and monitor on.
        do_reset('{default_src: 1'b0, two_speed: 1'b0, fail_safe: 1'b1, watchdog: 1'b1});
        chk("src", 8'(clk_out.src), 8'(SRC_INT));
        wr(ADDR_OSC_CTRL, 8'h02);
        cyc(4);
        chk("src", 8'(clk_out.src), 8'(SRC_INT));
        wait_src(SRC_PRI, 200);
        chk("pri flag", 8'(primary_ready_flag), 8'h01);
        chk("int en", 8'(osc_en.int_en), 8'h01);
        rd(ADDR_OSC_CTRL, 8'h0A);
        pulse(1'b0);
        chk("int en", 8'(osc_en.int_en), 8'h01);
        pulse(1'b1);
        chk("src", 8'(clk_out.src), 8'(SRC_INT));
        // Two-speed start-up boots on the internal oscillator, then moves to primary.
        do_reset('{default_src: 1'b1, two_speed: 1'b1, fail_safe: 1'b0, watchdog: 1'b0});
        chk("src", 8'(clk_out.src), 8'(SRC_INT));
        chk("pri flag", 8'(primary_ready_flag), 8'h00);
        wait_src(SRC_PRI, 200);
        chk("pri flag", 8'(primary_ready_flag), 8'h01);
        print_verdict();
    end

endmodule : tb_top

`default_nettype wire
